// File: hw/rtcf_defines.vh
// register offsets, field positions, reset values and timing counts for the
// rtc hours/weekday/month field block; definitions only
`ifndef RTCF_DEFINES_VH
`define RTCF_DEFINES_VH
`define RTCF_ADDR_HOUR 4'h9
`define RTCF_ADDR_WDAY 4'hA
`define RTCF_ADDR_MONTH 4'hB
`define RTCF_ADDR_CTRL 4'hE
`define RTCF_MERIDIEM_BIT 6
`define RTCF_HOUR_RST 6'h00
`define RTCF_WDAY_RST 7'h01
`define RTCF_MONTH_RST 5'h01
`define RTCF_CTRL_FMT_BIT 0
`define RTCF_CTRL_DEC_BIT 1
`define RTCF_CTRL_RST 2'h0
`define RTCF_CLK_HZ 25000000
`define RTCF_TICK_PERIOD_S 3600
`endif

// File: hw/rtcf_hour_step.v
// next-hour arithmetic for the hours field with meridiem flag
// assumes: field values legal for the selected format and coding
`timescale 1ns/1ps
`include "rtcf_defines.vh"
module rtcf_hour_step (
   // current state and mode
   input wire [5:0] hour_in,
   input wire meridiem_in,
   input wire fmt24_in,
   input wire dec_in,
   // next state
   output reg [5:0] hour_out,
   output reg meridiem_out,
   output reg day_wrap_out
);
   reg [4:0] bin_v;
   reg [4:0] nxt_v;
   reg [4:0] sub_v;
   always @* begin
      nxt_v = 5'h00;
      sub_v = 5'h00;
      // tens digit times ten is tens times eight plus tens times two
      bin_v = dec_in ? ({hour_in[5:4], 3'b000} + {2'b00, hour_in[5:4], 1'b0}
         + {1'b0, hour_in[3:0]}) : hour_in[4:0];
      meridiem_out = meridiem_in;
      day_wrap_out = 1'b0;
      if (fmt24_in) begin
         // 0..23, wrap starts a new day
         if (bin_v >= 5'h17) begin
            nxt_v = 5'h00;
            day_wrap_out = 1'b1;
         end else begin
            nxt_v = bin_v + 5'h01;
         end
      end else begin
         // 1..12; 11 -> 12 flips meridiem, pm to am is a new day
         if (bin_v >= 5'h0C) begin
            nxt_v = 5'h01;
         end else begin
            nxt_v = bin_v + 5'h01;
         end
         if (bin_v == 5'h0B) begin
            meridiem_out = ~meridiem_in;
            day_wrap_out = meridiem_in;
         end
      end
      if (dec_in) begin
         if (nxt_v >= 5'h14) begin
            sub_v = nxt_v - 5'h14;
            hour_out = {2'b10, sub_v[3:0]};
         end else if (nxt_v >= 5'h0A) begin
            sub_v = nxt_v - 5'h0A;
            hour_out = {2'b01, sub_v[3:0]};
         end else begin
            hour_out = {2'b00, nxt_v[3:0]};
         end
      end else begin
         hour_out = {1'b0, nxt_v};
      end
   end
endmodule

// File: hw/rtcf_wday_rot.v
// one-hot weekday rotation, saturday followed by sunday
// assumes: a one-hot seven-bit input
`timescale 1ns/1ps
module rtcf_wday_rot #(
   parameter DAYS = 7
) (
   // current day
   input wire [DAYS-1:0] day_in,
   // next day
   output wire [DAYS-1:0] day_out
);
   genvar i;
   generate
      for (i = 0; i < DAYS; i = i + 1) begin : g_rot
         assign day_out[i] = day_in[(i + DAYS - 1) % DAYS];
      end
   endgenerate
endmodule

// File: hw/rtcf_fields.v
// rtc hours, meridiem, weekday and month registers behind a plain register port
// assumes: tick_in is a one-cycle pulse on sys_clk_in, one per hour
// Function
// - meridiem flag: 0 morning, 1 afternoon
// - format bit 1 selects 24-hour, 0 12-hour
// - 24-hour binary: bit5 zero, 0..23
// - 24-hour decimal: tens 0..2, units 0..9, <=23
// - 12-hour binary: bits5:4 zero, 1..12
// - 12-hour decimal: tens 0..1, units 0..9, <=12
// - weekday one-hot bits 6:0, exactly one set
// - bits 6..1 map Saturday down to Monday
// - bit 0 Sunday; reset value is Sunday
// - reserved bits unstored, written zero, read zero
// - meridiem ignored in 24-hour format
`timescale 1ns/1ps
`include "rtcf_defines.vh"
module rtcf_fields #(
   parameter DAYS = 7
) (
   // clock and reset
   input wire sys_clk_in,
   input wire rst_in,
   // timekeeping tick
   input wire tick_in,
   // register port
   input wire [3:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [7:0] reg_rdata_out,
   // status
   output wire [DAYS-1:0] weekday_out,
   output wire day_error_out,
   output wire hour_error_out
);
   // hour and meridiem state
   reg [5:0] hour_q;
   reg [5:0] hour_d;
   reg meridiem_q;
   reg meridiem_d;
   // weekday and month state
   reg [DAYS-1:0] wday_q;
   wire [DAYS-1:0] wday_d;
   reg [4:0] month_q;
   reg [4:0] month_d;
   // control state
   reg fmt24_q;
   reg fmt24_d;
   reg dec_q;
   reg dec_d;
   // step results
   wire [5:0] hour_nxt;
   wire mer_nxt;
   wire wrap;
   wire day_step;
   wire [DAYS-1:0] wday_nxt;
   // write decode
   wire hour_wr;
   wire wday_wr;
   wire month_wr;
   wire ctrl_wr;
   // range checks
   wire [1:0] tens_w;
   wire [3:0] units_w;
   wire bin24_bad;
   wire dec24_bad;
   wire bin12_bad;
   wire dec12_bad;
   reg hour_bad;
   // weekday population
   wire [DAYS:0] seen_w;
   wire [DAYS:0] twice_w;
   // read path
   wire [7:0] hour_rd_w;
   wire [7:0] wday_rd_w;
   wire [7:0] month_rd_w;
   wire [7:0] ctrl_rd_w;
   reg [7:0] rdata_d;
   genvar b;

   rtcf_hour_step u_step (
      .hour_in(hour_q),
      .meridiem_in(meridiem_q),
      .fmt24_in(fmt24_q),
      .dec_in(dec_q),
      .hour_out(hour_nxt),
      .meridiem_out(mer_nxt),
      .day_wrap_out(wrap)
   );

   rtcf_wday_rot #(.DAYS(DAYS)) u_rot (
      .day_in(wday_q),
      .day_out(wday_nxt)
   );

   // write strobes per register
   assign hour_wr = reg_wr_in & (reg_addr_in == `RTCF_ADDR_HOUR);
   assign wday_wr = reg_wr_in & (reg_addr_in == `RTCF_ADDR_WDAY);
   assign month_wr = reg_wr_in & (reg_addr_in == `RTCF_ADDR_MONTH);
   assign ctrl_wr = reg_wr_in & (reg_addr_in == `RTCF_ADDR_CTRL);
   assign day_step = tick_in & wrap;

   // range check digits of the stored hour
   assign tens_w = hour_q[5:4];
   assign units_w = hour_q[3:0];
   assign bin24_bad = hour_q[5] | (hour_q[4:0] > 5'h17);
   assign dec24_bad = (tens_w > 2'h2) | (units_w > 4'h9) |
      ((tens_w == 2'h2) & (units_w > 4'h3));
   assign bin12_bad = (tens_w != 2'h0) | (units_w == 4'h0) |
      (units_w > 4'hC);
   assign dec12_bad = tens_w[1] | (units_w > 4'h9) | (hour_q == 6'h00) |
      (tens_w[0] & (units_w > 4'h2));

   // range check against the selected format and coding
   always @* begin
      hour_bad = 1'b0;
      case ({fmt24_q, dec_q})
         2'b10: begin
            hour_bad = bin24_bad;
         end
         2'b11: begin
            hour_bad = dec24_bad;
         end
         2'b00: begin
            hour_bad = bin12_bad;
         end
         2'b01: begin
            hour_bad = dec12_bad;
         end
         default: begin
            hour_bad = 1'b0;
         end
      endcase
   end
   assign hour_error_out = hour_bad;

   // exactly-one check, one stage per weekday bit
   assign seen_w[0] = 1'b0;
   assign twice_w[0] = 1'b0;
   generate
      for (b = 0; b < DAYS; b = b + 1) begin : g_one
         assign seen_w[b + 1] = seen_w[b] | wday_q[b];
         assign twice_w[b + 1] = twice_w[b] | (seen_w[b] & wday_q[b]);
      end
   endgenerate
   assign day_error_out = ~seen_w[DAYS] | twice_w[DAYS];
   assign weekday_out = wday_q;

   // hour and meridiem next value; software write beats tick
   always @* begin
      hour_d = hour_q;
      meridiem_d = meridiem_q;
      if (tick_in) begin
         hour_d = hour_nxt;
         // flag holds the am/pm state only in 12-hour format
         if (!fmt24_q) begin
            meridiem_d = mer_nxt;
         end
      end
      if (hour_wr) begin
         hour_d = reg_wdata_in[5:0];
         meridiem_d = reg_wdata_in[`RTCF_MERIDIEM_BIT];
      end
   end

   // weekday next value per bit; software write beats the day step
   generate
      for (b = 0; b < DAYS; b = b + 1) begin : g_wday
         assign wday_d[b] = wday_wr ? reg_wdata_in[b] :
            (day_step ? wday_nxt[b] : wday_q[b]);
      end
   endgenerate

   // month next value, stored raw
   always @* begin
      month_d = month_q;
      if (month_wr) begin
         month_d = reg_wdata_in[4:0];
      end
   end

   // control next value
   always @* begin
      fmt24_d = fmt24_q;
      dec_d = dec_q;
      if (ctrl_wr) begin
         fmt24_d = reg_wdata_in[`RTCF_CTRL_FMT_BIT];
         dec_d = reg_wdata_in[`RTCF_CTRL_DEC_BIT];
      end
   end

   // hour register
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         hour_q <= `RTCF_HOUR_RST;
      end else begin
         hour_q <= hour_d;
      end
   end

   // meridiem flag, morning after reset
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         meridiem_q <= 1'b0;
      end else begin
         meridiem_q <= meridiem_d;
      end
   end

   // weekday register, sunday after reset
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         wday_q <= `RTCF_WDAY_RST;
      end else begin
         wday_q <= wday_d;
      end
   end

   // month register
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         month_q <= `RTCF_MONTH_RST;
      end else begin
         month_q <= month_d;
      end
   end

   // hour format select
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         fmt24_q <= 1'b0;
      end else begin
         fmt24_q <= fmt24_d;
      end
   end

   // decimal coding select
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         dec_q <= 1'b0;
      end else begin
         dec_q <= dec_d;
      end
   end

   // read fields; reserved bits have no storage and read as zero
   assign hour_rd_w = {1'b0, meridiem_q, hour_q};
   assign wday_rd_w = {{(8 - DAYS){1'b0}}, wday_q};
   assign month_rd_w = {3'b000, month_q};
   assign ctrl_rd_w = {6'h00, dec_q, fmt24_q};

   // read mux; unmapped addresses read as zero
   always @* begin
      rdata_d = 8'h00;
      case (reg_addr_in)
         `RTCF_ADDR_HOUR: begin
            rdata_d = hour_rd_w;
         end
         `RTCF_ADDR_WDAY: begin
            rdata_d = wday_rd_w;
         end
         `RTCF_ADDR_MONTH: begin
            rdata_d = month_rd_w;
         end
         `RTCF_ADDR_CTRL: begin
            rdata_d = ctrl_rd_w;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   // read data stand for the one cycle after the strobe, zero otherwise
   always @(posedge sys_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_d;
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

endmodule

// File: sim/rtcf_props.sv
// port checker for rtcf_fields
// assumes: one clock, sync reset
`timescale 1ns/1ps
module rtcf_props #(parameter DAYS = 7) (
   // watched ports
   input wire sys_clk_in,
   input wire rst_in,
   input wire tick_in,
   input wire [3:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_rdata_out,
   input wire [DAYS-1:0] weekday_out,
   input wire day_error_out,
   input wire hour_error_out
);
   wire [DAYS-1:0] rot = {weekday_out[DAYS-2:0], weekday_out[DAYS-1]};
   wire [DAYS-1:0] wdat = reg_wdata_in[DAYS-1:0];
   wire wd_wr = reg_wr_in && reg_addr_in == 4'hA;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   a_wday_onehot: assert property ($onehot(weekday_out) && !day_error_out)
      else $error("weekday not one-hot");
   a_rst_sunday: assert property (disable iff (1'b0) rst_in |=> weekday_out == 7'h01)
      else $error("weekday reset wrong");
   a_rd_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data not idle");
   a_rd_wday: assert property (
      reg_rd_in && reg_addr_in == 4'hA |=> reg_rdata_out == {1'b0, $past(weekday_out)})
      else $error("weekday read wrong");
   a_rd_unmapped: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> !reg_rdata_out)
      else $error("unmapped read not zero");
   a_wday_hold: assert property (!tick_in && !wd_wr |=> $stable(weekday_out))
      else $error("weekday moved");
   a_wday_rot: assert property (
      tick_in && !wd_wr |=> weekday_out == $past(weekday_out) || weekday_out == $past(rot))
      else $error("weekday step wrong");
   a_wday_write: assert property (wd_wr |=> weekday_out == $past(wdat))
      else $error("weekday write lost");
   c_tick: cover property (tick_in && !wd_wr);
   c_wd_rd: cover property (reg_rd_in && reg_addr_in == 4'hA);
   c_wd_wr: cover property (wd_wr);
endmodule
bind rtcf_fields rtcf_props #(.DAYS(DAYS)) p_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
   .tick_in(tick_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .weekday_out(weekday_out), .day_error_out(day_error_out),
   .hour_error_out(hour_error_out));

// File: sim/tb.sv
// register-level bench for rtcf_fields
// assumes: 25 MHz clock, bench drives all ports
`timescale 1ns/1ps
module tb;
   reg sys_clk_in = 1'b0;
   reg rst_in = 1'b1;
   reg tick_in = 1'b0;
   reg [3:0] reg_addr_in = 4'h0;
   reg [7:0] reg_wdata_in = 8'h00;
   reg reg_wr_in = 1'b0;
   reg reg_rd_in = 1'b0;
   wire [7:0] reg_rdata_out;
   wire [6:0] weekday_out;
   wire day_error_out;
   wire hour_error_out;
   integer miscompares = 0;
   integer total_checks = 0;
   integer i;
   reg [31:0] tab [0:6];
   always #20 sys_clk_in = ~sys_clk_in;
   rtcf_fields dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .tick_in(tick_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .weekday_out(weekday_out),
      .day_error_out(day_error_out), .hour_error_out(hour_error_out));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge sys_clk_in);
         reg_addr_in <= a;
         reg_wdata_in <= d;
         reg_wr_in <= 1'b1;
         @(posedge sys_clk_in);
         reg_wr_in <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         @(posedge sys_clk_in);
         reg_addr_in <= a;
         reg_rd_in <= 1'b1;
         @(posedge sys_clk_in);
         reg_rd_in <= 1'b0;
         @(negedge sys_clk_in);
         chk(reg_rdata_out, e);
      end
   endtask
   task tick;
      begin
         @(posedge sys_clk_in);
         tick_in <= 1'b1;
         @(posedge sys_clk_in);
         tick_in <= 1'b0;
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      #200000;
      miscompares = miscompares + 1;
      give_verdict;
   end
   initial begin
      // control, hour before, hour after, weekday wraps
      tab[0] = 32'h0117_0001;
      tab[1] = 32'h0323_0001;
      tab[2] = 32'h004B_0C01;
      tab[3] = 32'h000B_4C00;
      tab[4] = 32'h0211_5200;
      tab[5] = 32'h0251_1201;
      tab[6] = 32'h0145_4600;
      repeat (16) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd(4'hA, 8'h01);
      rd(4'h9, 8'h00);
      rd(4'h0, 8'h00);
      wr(4'hA, 8'h04);
      rd(4'hA, 8'h04);
      wr(4'hB, 8'h0C);
      rd(4'hB, 8'h0C);
      $display("test registers done");
      for (i = 0; i < 7; i = i + 1) begin
         wr(4'hE, tab[i][31:24]);
         wr(4'hA, 8'h40);
         wr(4'h9, tab[i][23:16]);
         tick;
         rd(4'h9, tab[i][15:8]);
         rd(4'hA, tab[i][0] ? 8'h01 : 8'h40);
      end
      $display("test hour steps done");
      wr(4'hE, 8'h01);
      wr(4'h9, 8'h18);
      @(negedge sys_clk_in);
      chk({7'h00, hour_error_out}, 8'h01);
      wr(4'h9, 8'h00);
      @(negedge sys_clk_in);
      chk({7'h00, hour_error_out}, 8'h00);
      wr(4'hE, 8'h00);
      @(negedge sys_clk_in);
      chk({7'h00, hour_error_out}, 8'h01);
      $display("test hour range done");
      give_verdict;
   end
endmodule
